// *** common/sspsig_cfg.svh ***
// constants for the serial port signalling ends
// assumes inclusion by both ends and the testbench
//
// Notes on behaviour
// (R01) control line asserted when positive leg low
// (R02) data one when positive leg high
// (R03) links carry at least one megabit per second
// (R04) addresses: cpu 19, field io 20, 255 broadcast
// (R05) unassigned addresses never used on own initiative
// (R06) response echoes the command sender's address; the code echoes the frame's address field
// (R07) slot empty holds drivers and receivers disabled
// (R08) channel a is port one, b auxiliary
// (R09) auxiliary port synchronous at 614.4 kbps; the divider gives 625 kbps
// (R10) outgoing reset is cpu reset or powerup; the code also asserts it on RST
// (R11) line sync and power fail driven separately
// (R12) accept only own or broadcast address frames
`ifndef SSPSIG_CFG_SVH
`define SSPSIG_CFG_SVH
`define SSPSIG_CLK_HZ 25000000
`define SSPSIG_LINK_BPS 1000000
`define SSPSIG_AUX_BPS 614400
`define SSPSIG_LINK_DIV (`SSPSIG_CLK_HZ / `SSPSIG_LINK_BPS)
`define SSPSIG_AUX_DIV (`SSPSIG_CLK_HZ / `SSPSIG_AUX_BPS)
`define SSPSIG_ADDR_CPU 8'h13
`define SSPSIG_ADDR_FIELD_IO 8'h14
`define SSPSIG_ADDR_MFR_LO 8'h80
`define SSPSIG_ADDR_MFR_HI 8'hFE
`define SSPSIG_ADDR_BCAST 8'hFF
`define SSPSIG_FLAG 8'h7E
`endif

// *** common/sspsig_pkg.sv ***
// types shared by the serial port signalling ends
// assumes the constants header is included alongside
package sspsig_pkg;
  typedef enum logic [1:0] {SSPSIG_IDLE, SSPSIG_FLAG1, SSPSIG_ADDR, SSPSIG_DATA} sspsig_state_type;
  typedef logic [7:0] sspsig_addr_type;
  // a differential pair as two single-ended legs
  typedef struct packed {logic pos; logic neg;} sspsig_diff_type;
endpackage : sspsig_pkg

// *** common/sspsig_if.sv ***
// link between the cpu end and a field station end
// assumes one shared SYS_CLK; pairs resolved by the bench
`timescale 1ns/1ps
`default_nettype none
interface sspsig_if;
  import sspsig_pkg::*;
  logic cmd_pos;
  logic cmd_neg;
  logic cmd_oe;
  logic rsp_pos;
  logic rsp_neg;
  logic rsp_oe;
  logic rts_pos;
  logic rts_neg;
  logic slot_gnd;
  modport cpu_end (output cmd_pos, output cmd_neg, output cmd_oe, output rts_pos, output rts_neg,
    input rsp_pos, input rsp_neg, input rsp_oe, input slot_gnd);
  modport station_end (input cmd_pos, input cmd_neg, input cmd_oe, input rts_pos, input rts_neg,
    output rsp_pos, output rsp_neg, output rsp_oe, output slot_gnd);
endinterface : sspsig_if
`default_nettype wire

// *** verilog/sspsig_cpu.sv ***
// cpu end: frames commands, checks echoed address, drives front-panel pairs
// assumes station end on the link, bytes offered with a valid/ready strobe
`timescale 1ns/1ps
`default_nettype none
`include "sspsig_cfg.svh"
module sspsig_cpu
  import sspsig_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST,
  sspsig_if.cpu_end LINK,
  input wire logic TX_VALID,
  input wire logic [7:0] TX_ADDR,
  input wire logic [7:0] TX_DATA,
  output logic TX_READY,
  output logic [7:0] RX_DATA,
  output logic RX_VALID,
  output logic RX_ADDR_OK,
  input wire logic CPU_RESET,
  input wire logic POWER_UP_RESET,
  input wire logic MAINS_LINE_SYNC,
  input wire logic POWER_FAIL_INDICATION,
  output logic COMBINED_EXTERNAL_RESET_N_POS,
  output logic COMBINED_EXTERNAL_RESET_N_NEG,
  output logic MAINS_LINE_SYNC_POS,
  output logic MAINS_LINE_SYNC_NEG,
  output logic POWER_FAIL_POS,
  output logic POWER_FAIL_NEG,
  output logic AUX_SYNC_CLK_EN
);
  // (R04) assigned, manufacturer and broadcast addresses only
  function automatic logic addr_legal(input sspsig_addr_type a);
    addr_legal = (a == `SSPSIG_ADDR_CPU) || (a == `SSPSIG_ADDR_FIELD_IO) || (a == `SSPSIG_ADDR_BCAST)
      || ((a >= `SSPSIG_ADDR_MFR_LO) && (a <= `SSPSIG_ADDR_MFR_HI));
  endfunction : addr_legal

  sspsig_state_type state;
  sspsig_state_type next_state;
  logic [4:0] bit_cnt;
  logic [2:0] bit_idx;
  logic [7:0] shreg;
  logic [7:0] last_addr;
  logic [7:0] rx_shreg;
  logic [3:0] rx_bits;
  logic [5:0] aux_cnt;
  logic [4:0] rx_cnt;
  logic tx_bit;
  logic slot_ok;
  logic [7:0] next_shreg;
  logic [2:0] next_bit_idx;
  logic next_tx_bit;
  wire bit_tick = (bit_cnt == 5'(`SSPSIG_LINK_DIV - 1));
  wire byte_done = bit_tick && (bit_idx == 3'h7);
  wire rsp_bit = LINK.rsp_pos & ~LINK.rsp_neg;
  wire in_idle = (state == SSPSIG_IDLE);
  wire in_flag = (state == SSPSIG_FLAG1);
  wire take = TX_READY && TX_VALID;
  // receiver has its own counter: the frame counter rests in idle
  wire rx_run = slot_ok && LINK.rsp_oe;
  wire rx_tick = (rx_cnt == 5'(`SSPSIG_LINK_DIV - 1));
  wire rx_mid = (rx_cnt == 5'(`SSPSIG_LINK_DIV / 2));
  wire rx_last = rx_mid && (rx_bits == 4'h7);
  wire [7:0] rx_byte = {rsp_bit, rx_shreg[7:1]};
  // (R08) link is channel a, aux is channel b
  wire aux_wrap = (aux_cnt == 6'(`SSPSIG_AUX_DIV - 1));
  // (R10) high while any reset source
  wire reset_any = CPU_RESET | POWER_UP_RESET | RST;

  // (R07) slot ground gates the command driver, the receiver and the aux enable
  assign slot_ok = LINK.slot_gnd;
  // (R05) illegal addresses refused at the strobe
  // half duplex: no new command while the station answers
  assign TX_READY = slot_ok && in_idle && !LINK.rsp_oe && addr_legal(TX_ADDR);
  // (R02) data one as positive leg high
  assign LINK.cmd_pos = tx_bit;
  assign LINK.cmd_neg = ~tx_bit;
  assign LINK.cmd_oe = slot_ok && (state != SSPSIG_IDLE);
  // (R01) request to send asserted as positive low
  assign LINK.rts_pos = ~LINK.cmd_oe;
  assign LINK.rts_neg = LINK.cmd_oe;

  always_comb begin
    next_state = state;
    unique case (state)
      SSPSIG_IDLE: if (take) next_state = SSPSIG_FLAG1;
      SSPSIG_FLAG1: if (byte_done) next_state = SSPSIG_ADDR;
      SSPSIG_ADDR: if (byte_done) next_state = SSPSIG_DATA;
      SSPSIG_DATA: if (byte_done) next_state = SSPSIG_IDLE;
    endcase
    if (!slot_ok) next_state = SSPSIG_IDLE;
  end

  // next shift register and bit index
  always_comb begin
    next_shreg = shreg;
    next_bit_idx = bit_idx;
    if (take) begin
      next_shreg = `SSPSIG_FLAG;
      next_bit_idx = 3'h0;
    end else if (byte_done) begin
      next_shreg = in_flag ? last_addr : TX_DATA;
      next_bit_idx = 3'h0;
    end else if (bit_tick) begin
      next_shreg = {1'b0, shreg[7:1]};
      next_bit_idx = bit_idx + 3'h1;
    end
  end

  // line idles high between frames
  assign next_tx_bit = in_idle ? 1'b1 : shreg[0];

  // (R03) bit timing at one megabit
  always_ff @(posedge SYS_CLK) begin
    if (RST || in_idle || bit_tick) bit_cnt <= 5'h00;
    else bit_cnt <= bit_cnt + 5'h01;
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      state <= SSPSIG_IDLE;
      bit_idx <= 3'h0;
      shreg <= 8'h00;
      last_addr <= 8'h00;
      tx_bit <= 1'b1;
    end else begin
      state <= next_state;
      bit_idx <= next_bit_idx;
      shreg <= next_shreg;
      tx_bit <= next_tx_bit;
      if (take) last_addr <= TX_ADDR;
    end
  end

  // response: one byte, the echoed address, sampled mid-bit
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      rx_shreg <= 8'h00;
      rx_bits <= 4'h0;
      rx_cnt <= 5'h00;
      RX_VALID <= 1'b0;
      RX_DATA <= 8'h00;
      RX_ADDR_OK <= 1'b0;
    end else if (!rx_run) begin
      rx_shreg <= 8'h00;
      rx_bits <= 4'h0;
      rx_cnt <= 5'h00;
      RX_VALID <= 1'b0;
    end else begin
      RX_VALID <= 1'b0;
      rx_cnt <= rx_tick ? 5'h00 : rx_cnt + 5'h01;
      if (rx_mid) begin
        rx_shreg <= rx_byte;
        rx_bits <= rx_bits + 4'h1;
      end
      if (rx_last) begin
        RX_DATA <= rx_byte;
        RX_VALID <= 1'b1;
        // (R06) response must carry the commanded address
        RX_ADDR_OK <= (rx_byte == last_addr);
      end
    end
  end

  // (R09) auxiliary port bit enable, truncated divider
  // integer divide gives 625k; 41 would give the closer 609.8k
  always_ff @(posedge SYS_CLK) begin
    if (RST || aux_wrap) aux_cnt <= 6'h00;
    else aux_cnt <= aux_cnt + 6'h01;
    AUX_SYNC_CLK_EN <= !RST && slot_ok && (aux_cnt == 6'h00);
  end

  // (R10) reset pair, registered, active low
  always_ff @(posedge SYS_CLK) begin
    COMBINED_EXTERNAL_RESET_N_POS <= ~reset_any;
    COMBINED_EXTERNAL_RESET_N_NEG <= reset_any;
  end

  // (R11) line sync and power fail pairs
  always_ff @(posedge SYS_CLK) begin
    MAINS_LINE_SYNC_POS <= MAINS_LINE_SYNC;
    MAINS_LINE_SYNC_NEG <= ~MAINS_LINE_SYNC;
    POWER_FAIL_POS <= POWER_FAIL_INDICATION;
    POWER_FAIL_NEG <= ~POWER_FAIL_INDICATION;
  end
endmodule : sspsig_cpu
`default_nettype wire

// *** verilog/sspsig_station.sv ***
// station end: accepts own or broadcast frames, echoes address back for own-address frames
// assumes cpu end on the link; shares SYS_CLK
`timescale 1ns/1ps
`default_nettype none
`include "sspsig_cfg.svh"
module sspsig_station
  import sspsig_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST,
  sspsig_if.station_end LINK,
  input wire logic [7:0] OWN_ADDR,
  input wire logic SLOT_PRESENT,
  output logic [7:0] RX_DATA,
  output logic RX_VALID,
  output logic RX_BCAST
);
  logic [4:0] bit_cnt;
  logic [7:0] sh;
  logic [4:0] nbits;
  logic [7:0] addr;
  logic [7:0] echo;
  logic echoing;
  logic [3:0] echo_idx;
  logic [4:0] echo_cnt;
  logic pending;
  wire active = LINK.cmd_oe;
  // (R01) rts asserted when positive leg low
  wire rts = ~LINK.rts_pos & LINK.rts_neg;
  // (R02) one when positive leg high
  wire rx_bit = LINK.cmd_pos & ~LINK.cmd_neg;
  // (R12) own address or broadcast only
  wire accept = (addr == OWN_ADDR) || (addr == `SSPSIG_ADDR_BCAST);

  assign LINK.slot_gnd = SLOT_PRESENT;
  // (R06) echo the frame's address bits
  assign LINK.rsp_pos = echo[0];
  assign LINK.rsp_neg = ~echo[0];
  assign LINK.rsp_oe = echoing;

  always_ff @(posedge SYS_CLK) begin
    if (RST || !active || !rts) begin
      bit_cnt <= 5'h00;
      sh <= 8'h00;
      nbits <= 5'h00;
      addr <= 8'h00;
      RX_VALID <= 1'b0;
      RX_DATA <= 8'h00;
      RX_BCAST <= 1'b0;
    end else begin
      RX_VALID <= 1'b0;
      bit_cnt <= (bit_cnt == 5'(`SSPSIG_LINK_DIV - 1)) ? 5'h00 : bit_cnt + 5'h01;
      // sample mid-bit for margin against skew
      if (bit_cnt == 5'(`SSPSIG_LINK_DIV / 2)) begin
        sh <= {rx_bit, sh[7:1]};
        nbits <= nbits + 5'h01;
        if (nbits == 5'h0F) addr <= {rx_bit, sh[7:1]};
        if (nbits == 5'h17 && accept) begin
          RX_DATA <= {rx_bit, sh[7:1]};
          RX_VALID <= 1'b1;
          RX_BCAST <= (addr == `SSPSIG_ADDR_BCAST);
        end
      end
    end
  end

  // broadcast gets no answer, so the bus never sees two talkers
  // answer waits for the command driver to let go
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      echoing <= 1'b0;
      pending <= 1'b0;
      echo <= 8'h00;
      echo_idx <= 4'h0;
      echo_cnt <= 5'h00;
    end else if (RX_VALID && !RX_BCAST && SLOT_PRESENT) begin
      pending <= 1'b1;
      echo <= addr;
    end else if (pending && !active) begin
      pending <= 1'b0;
      echoing <= 1'b1;
      echo_idx <= 4'h0;
      echo_cnt <= 5'h00;
    end else if (echoing) begin
      if (echo_cnt == 5'(`SSPSIG_LINK_DIV - 1)) begin
        echo_cnt <= 5'h00;
        echo <= {1'b0, echo[7:1]};
        echo_idx <= echo_idx + 4'h1;
        if (echo_idx == 4'h7) echoing <= 1'b0;
      end else begin
        echo_cnt <= echo_cnt + 5'h01;
      end
    end
  end
endmodule : sspsig_station
`default_nettype wire

// *** verif/sspsig_link_asserts.sv ***
// assertions on the link between the cpu end and a station end
// assumes instantiation beside the interface, one clock domain
`timescale 1ns/1ps
`default_nettype none
module sspsig_link_asserts (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic cmd_pos,
  input wire logic cmd_neg,
  input wire logic cmd_oe,
  input wire logic rsp_pos,
  input wire logic rsp_neg,
  input wire logic rsp_oe,
  input wire logic rts_pos,
  input wire logic rts_neg,
  input wire logic slot_gnd
);
  logic prev;
  logic [10:0] run;
  logic [10:0] len;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  // bit time and frame length; a long frame means a too slow link
  always_ff @(posedge SYS_CLK) begin
    prev <= cmd_pos;
    run <= (!cmd_oe || cmd_pos != prev) ? 11'h000 : run + 11'h001;
    len <= cmd_oe ? len + 11'h001 : 11'h000;
  end
  rts_legs_a: assert property (cmd_oe |-> !rts_pos && rts_neg) else $error("rts not asserted in frame");
  data_legs_a: assert property (cmd_oe |-> cmd_pos != cmd_neg) else $error("command legs equal");
  rsp_legs_a: assert property (rsp_oe |-> rsp_pos != rsp_neg) else $error("response legs equal");
  flag_first_a: assert property ($rose(cmd_oe) |-> ##2 (!cmd_pos)[*8]) else $error("frame not led by zero");
  bit_hold_a: assert property (cmd_oe && $past(cmd_oe) && $past(cmd_oe, 2) && cmd_pos != prev |-> run >= 11'h014)
    else $error("bit too short");
  frame_len_a: assert property (cmd_oe |-> len < 11'h76C) else $error("frame too long");
  slot_off_a: assert property (!slot_gnd |-> ##[0:1] !cmd_oe) else $error("driver on, slot empty");
  slot_start_a: assert property ($rose(cmd_oe) |-> slot_gnd) else $error("frame began, slot empty");
  half_duplex_a: assert property (rsp_oe |-> !cmd_oe) else $error("both ends driving");
endmodule : sspsig_link_asserts
`default_nettype wire

// *** verif/testbench.sv ***
// bench joining the cpu end and a station end over the link
// assumes the shared package, interface and constants header
`timescale 1ns/1ps
`default_nettype none
`include "sspsig_cfg.svh"
module testbench;
  import sspsig_pkg::*;
  logic clk = 0, rst = 1, tv = 0, cr = 0, pr = 0, ls = 0, pf = 0, slot = 1;
  logic [7:0] ta = 0, td = 0, own = 8'h14, crd, srd;
  logic trdy, crv, aok, srv, sbc, rp, rn, lp, ln, fp, fn, aux;
  int seed = 46, error_cnt = 0, cmp_count = 0, cyc = 0, i, n;
  sspsig_if link();
  sspsig_cpu u_sspsig_cpu(.SYS_CLK(clk), .RST(rst), .LINK(link), .TX_VALID(tv), .TX_ADDR(ta), .TX_DATA(td),
    .TX_READY(trdy), .RX_DATA(crd), .RX_VALID(crv), .RX_ADDR_OK(aok), .CPU_RESET(cr), .POWER_UP_RESET(pr),
    .MAINS_LINE_SYNC(ls), .POWER_FAIL_INDICATION(pf), .COMBINED_EXTERNAL_RESET_N_POS(rp),
    .COMBINED_EXTERNAL_RESET_N_NEG(rn), .MAINS_LINE_SYNC_POS(lp), .MAINS_LINE_SYNC_NEG(ln),
    .POWER_FAIL_POS(fp), .POWER_FAIL_NEG(fn), .AUX_SYNC_CLK_EN(aux));
  sspsig_station u_sspsig_station(.SYS_CLK(clk), .RST(rst), .LINK(link), .OWN_ADDR(own),
    .SLOT_PRESENT(slot), .RX_DATA(srd), .RX_VALID(srv), .RX_BCAST(sbc));
  sspsig_link_asserts u_sspsig_link_asserts(.SYS_CLK(clk), .RST(rst), .cmd_pos(link.cmd_pos),
    .cmd_neg(link.cmd_neg), .cmd_oe(link.cmd_oe), .rsp_pos(link.rsp_pos), .rsp_neg(link.rsp_neg),
    .rsp_oe(link.rsp_oe), .rts_pos(link.rts_pos), .rts_neg(link.rts_neg), .slot_gnd(link.slot_gnd));
  initial begin
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  function automatic logic legal(input logic [7:0] a);
    return a == `SSPSIG_ADDR_CPU || a == `SSPSIG_ADDR_FIELD_IO || a >= `SSPSIG_ADDR_MFR_LO;
  endfunction : legal
  // one command; waits long enough to see a late or missing delivery
  task automatic frame(input logic [7:0] a, input logic [7:0] d);
    logic got;
    logic gotr;
    got = 0;
    gotr = 0;
    @(posedge clk);
    ta <= a;
    td <= d;
    #1;
    chk(trdy, legal(a) && slot);
    if (trdy) begin
      @(posedge clk) tv <= 1;
      @(posedge clk) tv <= 0;
      for (n = 0; n < 2500; n++) begin
        @(posedge clk) #1;
        if (srv === 1'b1) begin
          got = 1;
          chk(srd, d);
          chk(sbc, a == `SSPSIG_ADDR_BCAST);
        end
        if (crv === 1'b1) begin
          gotr = 1;
          chk(crd, a);
          chk(aok, 1'b1);
        end
      end
      chk(gotr, a == own && a != `SSPSIG_ADDR_BCAST);
      chk(got, a == own || a == `SSPSIG_ADDR_BCAST);
      for (n = 0; n < 2000 && trdy !== 1'b1; n++) @(posedge clk) #1;
    end
    $display("frame %h done", a);
  endtask : frame
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      print_verdict;
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 0;
    // all input combinations first, then random ones
    for (i = 0; i < 32; i++) begin
      @(posedge clk);
      {cr, pr, ls, pf} <= (i < 16) ? i[3:0] : 4'($random(seed));
      @(posedge clk) #1;
      chk({rp, rn}, {!(cr | pr), cr | pr});
      chk({lp, ln, fp, fn}, {ls, !ls, pf, !pf});
    end
    $display("front panel pairs done");
    n = 0;
    for (i = 0; i < 400; i++) begin
      @(posedge clk) #1;
      n += aux;
    end
    chk(8'(n), 8'h0A);
    $display("aux rate done");
    frame(8'h14, 8'($random(seed)));
    frame(8'h13, 8'($random(seed)));
    frame(8'hFF, 8'($random(seed)));
    frame(8'h80, 8'h00);
    frame(8'hFE, 8'hFF);
    frame(8'h15, 8'($random(seed)));
    frame(8'h00, 8'($random(seed)));
    own <= 8'h13;
    frame(8'h13, 8'($random(seed)));
    own <= 8'h14;
    frame(8'($random(seed)), 8'($random(seed)));
    slot <= 0;
    repeat (3) @(posedge clk);
    frame(8'h14, 8'h5A);
    slot <= 1;
    repeat (3) @(posedge clk);
    frame(8'h14, 8'hA5);
    print_verdict;
  end
endmodule : testbench
`default_nettype wire
